// ===== test/bsz_port_model.sv
// Behavioural 8-bit or 16-bit port facing the bus sizing block
// Assumes the block clock; wide picks the port width, slow delays the acknowledge
module bsz_port_model (
   // Control
   input wire logic clk,
   input wire logic wide,
   input wire logic slow,
   // Bus
   input wire logic address_strobe_n,
   input wire logic read_write,
   input wire logic [bsz_pkg::ADDR_W-1:0] address,
   input wire logic [1:0] transfer_size_code,
   input wire logic [bsz_pkg::DATA_W-1:0] data_out,
   output logic [bsz_pkg::DATA_W-1:0] data_in,
   output logic ack_byte_port_n,
   output logic ack_word_port_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:15];
   logic acked = 1'h0;
   logic [2:0] cnt = 3'h0;
   logic [3:0] a;
   logic wrd;
   assign a = address[3:0];
   assign wrd = transfer_size_code == bsz_pkg::SIZE_WORD;
   assign ack_byte_port_n = !(acked && !wide);
   assign ack_word_port_n = !(acked && wide);
   initial data_in = 16'h5A5A;
   // ----------------------------------------
   // Answer one cycle
   // ----------------------------------------
   always @(posedge clk) begin
      if (address_strobe_n) begin
         acked <= 1'h0;
         cnt <= 3'h0;
         data_in <= ~data_in;
      end else if (!acked) begin
         cnt <= cnt + 3'h1;
         if (cnt >= (slow ? 3'h4 : 3'h0)) begin
            acked <= 1'h1;
            if (read_write) begin
               if (!wide) data_in <= {mem[a], ~mem[a]};
               else if (wrd && !a[0]) data_in <= {mem[a], mem[a+4'h1]};
               else if (a[0]) data_in <= {~mem[a], mem[a]};
               else data_in <= {mem[a], ~mem[a]};
            end else begin
               data_in <= ~data_in;
               if (!wide || !a[0]) begin
                  mem[a] <= data_out[15:8];
                  if (wide && wrd) mem[a+4'h1] <= data_out[7:0];
               end else mem[a] <= data_out[7:0];
            end
         end else begin
            data_in <= ~data_in;
         end
      end
   end
endmodule : bsz_port_model

// ===== test/tb.sv
// Self-checking bench for the bus sizing block
// Assumes bsz_pkg and the port model are compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, misalign_allowed, req_valid, req_ready, req_word, req_read, done, misalign_error;
   logic address_lsb, read_write, address_strobe_n, data_strobe_n, data_oe, ack_byte_port_n, ack_word_port_n;
   logic wide, slow, clk_en;
   logic [bsz_pkg::ADDR_W-1:0] req_addr, address;
   logic [bsz_pkg::FC_W-1:0] req_fc, function_code;
   logic [bsz_pkg::DATA_W-1:0] req_wdata, rdata, data_out, data_in;
   logic [1:0] transfer_size_code;
   logic [18:0] cyc_q[$];
   int bad_count, checked;
   bsz_core dut (.clk, .reset_n, .clk_en, .misalign_allowed, .req_valid, .req_ready, .req_word, .req_read,
      .req_addr, .req_fc, .req_wdata, .done, .misalign_error, .rdata, .address, .address_lsb, .transfer_size_code,
      .function_code, .read_write, .address_strobe_n, .data_strobe_n, .data_out, .data_oe, .data_in,
      .ack_byte_port_n, .ack_word_port_n);
   bsz_port_model port (.clk, .wide, .slow, .address_strobe_n, .read_write, .address, .transfer_size_code,
      .data_out, .data_in, .ack_byte_port_n, .ack_word_port_n);
   always #20 clk = ~clk;
   // ----------------------------------------
   // Checking and transfers
   // ----------------------------------------
   task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   always @(negedge address_strobe_n) begin
      #1;
      cyc_q.push_back({transfer_size_code, address_lsb, data_out});
      cmp(19'(function_code), 19'h5);
      cmp(19'({read_write, data_oe, data_strobe_n}), 19'({req_read, !req_read, 1'h0}));
   end
   task automatic xfer(input logic w, input logic r, input logic [23:0] a, input logic [15:0] d);
      int n;
      cyc_q = {};
      @(posedge clk);
      req_valid <= 1'h1;
      req_word <= w;
      req_read <= r;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req_valid <= 1'h0;
      #1;
      for (n = 0; n < 300 && done !== 1'h1 && misalign_error !== 1'h1; n++) @(posedge clk) #1;
      cmp(19'(n < 300), 19'h1);
   endtask : xfer
   task automatic t_byte8;
      wide = 1'h0;
      xfer(1'h0, 1'h0, 24'h000010, 16'h00A5);
      cmp(cyc_q[0], {2'h1, 1'h0, 16'hA5A5});
      xfer(1'h0, 1'h0, 24'h000011, 16'h003C);
      cmp(cyc_q[0], {2'h1, 1'h1, 16'h3C3C});
      xfer(1'h0, 1'h1, 24'h000010, 16'h0000);
      cmp(19'(rdata[7:0]), 19'hA5);
      xfer(1'h0, 1'h1, 24'h000011, 16'h0000);
      cmp(19'(rdata[7:0]), 19'h3C);
      $display("test byte to 8-bit port done");
   endtask : t_byte8
   task automatic t_byte16;
      wide = 1'h1;
      xfer(1'h0, 1'h0, 24'h000020, 16'h0011);
      xfer(1'h0, 1'h0, 24'h000021, 16'h0022);
      cmp(cyc_q[0], {2'h1, 1'h1, 16'h2222});
      xfer(1'h0, 1'h1, 24'h000021, 16'h0000);
      cmp(19'(rdata[7:0]), 19'h22);
      xfer(1'h0, 1'h1, 24'h000020, 16'h0000);
      cmp(19'(rdata[7:0]), 19'h11);
      xfer(1'h1, 1'h0, 24'h000024, 16'hCAFE);
      cmp(19'(cyc_q.size()), 19'h1);
      xfer(1'h1, 1'h1, 24'h000024, 16'h0000);
      cmp(19'(rdata), 19'hCAFE);
      $display("test byte to 16-bit port done");
   endtask : t_byte16
   task automatic t_freeze;
      cyc_q = {};
      @(posedge clk);
      clk_en <= 1'h0;
      req_valid <= 1'h1;
      req_word <= 1'h0;
      req_read <= 1'h0;
      req_addr <= 24'h000040;
      req_wdata <= 16'h0077;
      repeat (4) @(posedge clk);
      clk_en <= 1'h1;
      req_valid <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      cmp(19'({req_ready, done, address == 24'h000040}), 19'h4);
      cmp(19'(cyc_q.size()), 19'h0);
      $display("test clock enable freeze done");
   endtask : t_freeze
   task automatic t_reset;
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      cmp(19'({address_strobe_n, data_strobe_n, data_oe, read_write, req_ready, done}), 19'h36);
      cmp(19'(transfer_size_code), 19'(bsz_pkg::SIZE_BYTE));
      cmp(19'(rdata), 19'h0);
      @(posedge clk);
      reset_n <= 1'h1;
      $display("test reset in mid-run done");
   endtask : t_reset
   task automatic t_word8;
      wide = 1'h0;
      slow = 1'h1;
      xfer(1'h1, 1'h0, 24'h000030, 16'hBEEF);
      cmp(19'(cyc_q.size()), 19'h2);
      cmp(cyc_q[0], {2'h2, 1'h0, 16'hBEEF});
      cmp(19'(cyc_q[1][18:8]), {8'h0, 2'h1, 1'h1, 8'hEF});
      xfer(1'h1, 1'h1, 24'h000030, 16'h0000);
      cmp(19'(rdata), 19'hBEEF);
      slow = 1'h0;
      $display("test word to 8-bit port done");
   endtask : t_word8
   task automatic t_mis8;
      misalign_allowed <= 1'h1;
      xfer(1'h1, 1'h0, 24'h000033, 16'h1234);
      cmp(19'(cyc_q[0][18:8]), {8'h0, 2'h2, 1'h1, 8'h12});
      cmp(19'(cyc_q[1][18:8]), {8'h0, 2'h1, 1'h0, 8'h34});
      xfer(1'h1, 1'h1, 24'h000033, 16'h0000);
      cmp(19'(rdata), 19'h1234);
      wide = 1'h1;
      xfer(1'h1, 1'h0, 24'h000037, 16'h5678);
      cmp(19'(cyc_q.size()), 19'h2);
      cmp(cyc_q[0], {2'h2, 1'h1, 16'h5656});
      cmp(cyc_q[1], {2'h1, 1'h0, 16'h7878});
      xfer(1'h1, 1'h1, 24'h000037, 16'h0000);
      cmp(19'(rdata), 19'h5678);
      wide = 1'h0;
      misalign_allowed <= 1'h0;
      xfer(1'h1, 1'h1, 24'h000035, 16'h0000);
      cmp(19'(misalign_error), 19'h1);
      cmp(19'(cyc_q.size()), 19'h0);
      $display("test misaligned word done");
   endtask : t_mis8
   task automatic conclude;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      clk = 1'h0;
      reset_n = 1'h0;
      {misalign_allowed, req_valid, req_word, req_read, wide, slow} = 6'h0;
      clk_en = 1'h1;
      req_addr = 24'h000000;
      req_fc = 3'h5;
      req_wdata = 16'h0000;
      repeat (6) @(posedge clk);
      reset_n <= 1'h1;
      t_byte8();
      t_byte16();
      t_freeze();
      t_reset();
      t_word8();
      t_mis8();
      conclude();
   end
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
endmodule : tb

// ===== verilog/bsz_core.sv
// Dynamic bus sizing master for byte and word operands on a 16-bit bus
// Assumes ports answer with active-low size acknowledges and hold them until the strobes negate
module bsz_core (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Variant select
   input wire logic misalign_allowed,
   // Request from core
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_word,
   input wire logic req_read,
   input wire logic [bsz_pkg::ADDR_W-1:0] req_addr,
   input wire logic [bsz_pkg::FC_W-1:0] req_fc,
   input wire logic [bsz_pkg::DATA_W-1:0] req_wdata,
   // Answer to core
   output logic done,
   output logic misalign_error,
   output logic [bsz_pkg::DATA_W-1:0] rdata,
   // External bus
   output logic [bsz_pkg::ADDR_W-1:0] address,
   output logic address_lsb,
   output logic [1:0] transfer_size_code,
   output logic [bsz_pkg::FC_W-1:0] function_code,
   output logic read_write,
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic [bsz_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [bsz_pkg::DATA_W-1:0] data_in,
   input wire logic ack_byte_port_n,
   input wire logic ack_word_port_n
);
   bsz_pkg::bsz_state_e state;
   logic ack_byte_s_n;
   logic ack_word_s_n;
   logic [7:0] op_first;
   logic [7:0] op_second;
   logic second_cycle;
   logic acked;
   logic byte_port;

   // ----------------------------------------
   // Acknowledge synchronisers
   // ----------------------------------------
   bsz_sync u_sync_byte (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .async_n(ack_byte_port_n),
      .sync_n(ack_byte_s_n)
   );
   bsz_sync u_sync_word (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .async_n(ack_word_port_n),
      .sync_n(ack_word_s_n)
   );

   assign acked = !ack_byte_s_n || !ack_word_s_n;
   assign byte_port = !ack_byte_s_n && ack_word_s_n;
   assign address_lsb = address[0];
   assign address_strobe_n = !(state == bsz_pkg::BSZ_WAIT);
   assign data_strobe_n = !(state == bsz_pkg::BSZ_WAIT);
   assign req_ready = (state == bsz_pkg::BSZ_IDLE);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= bsz_pkg::BSZ_IDLE;
      end else if (clk_en) begin
         case (state)
            bsz_pkg::BSZ_IDLE: begin
               if (req_valid && (misalign_allowed || !req_word || !req_addr[0])) begin
                  state <= bsz_pkg::BSZ_DRIVE;
               end
            end
            bsz_pkg::BSZ_DRIVE: begin
               state <= bsz_pkg::BSZ_WAIT;
            end
            bsz_pkg::BSZ_WAIT: begin
               if (acked) begin
                  state <= bsz_pkg::BSZ_RELEASE;
               end
            end
            bsz_pkg::BSZ_RELEASE: begin
               if (acked) begin
                  state <= bsz_pkg::BSZ_RELEASE;
               end else if (second_cycle) begin
                  state <= bsz_pkg::BSZ_NEXT;
               end else begin
                  state <= bsz_pkg::BSZ_IDLE;
               end
            end
            bsz_pkg::BSZ_NEXT: begin
               state <= bsz_pkg::BSZ_DRIVE;
            end
            default: begin
               state <= bsz_pkg::BSZ_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Address, size and attributes
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         address <= bsz_pkg::ADDR_RESET;
         transfer_size_code <= bsz_pkg::SIZE_BYTE;
         function_code <= '0;
         read_write <= 1'b1;
         op_first <= 8'h00;
         op_second <= 8'h00;
         second_cycle <= 1'b0;
      end else if (clk_en) begin
         if (state == bsz_pkg::BSZ_IDLE && req_valid) begin
            address <= req_addr;
            transfer_size_code <= req_word ? bsz_pkg::SIZE_WORD : bsz_pkg::SIZE_BYTE;
            function_code <= req_fc;
            read_write <= req_read;
            op_first <= req_word ? req_wdata[bsz_pkg::BYTE_HI:8] : req_wdata[bsz_pkg::BYTE_LO:0];
            op_second <= req_wdata[bsz_pkg::BYTE_LO:0];
         end
         if (state == bsz_pkg::BSZ_WAIT && acked) begin
            second_cycle <= (transfer_size_code == bsz_pkg::SIZE_WORD) &&
               (byte_port || address[0]);
         end
         if (state == bsz_pkg::BSZ_NEXT) begin
            address <= address + 24'h000001;
            transfer_size_code <= bsz_pkg::SIZE_BYTE;
            op_first <= op_second;
            second_cycle <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Write lanes
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= bsz_pkg::DATA_RESET;
         data_oe <= 1'b0;
      end else if (clk_en) begin
         if (state == bsz_pkg::BSZ_DRIVE && !read_write) begin
            data_oe <= 1'b1;
            if (transfer_size_code == bsz_pkg::SIZE_WORD && !address[0]) begin
               data_out <= {op_first, op_second};
            end else begin
               data_out <= {op_first, op_first};
            end
         end else if (state == bsz_pkg::BSZ_IDLE) begin
            data_oe <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read capture and completion
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= bsz_pkg::DATA_RESET;
         done <= 1'b0;
         misalign_error <= 1'b0;
      end else if (clk_en) begin
         done <= state == bsz_pkg::BSZ_RELEASE && !acked && !second_cycle;
         misalign_error <= state == bsz_pkg::BSZ_IDLE && req_valid && !misalign_allowed &&
            req_word && req_addr[0];
         if (state == bsz_pkg::BSZ_WAIT && acked && read_write) begin
            if (transfer_size_code == bsz_pkg::SIZE_WORD && !byte_port && !address[0]) begin
               rdata <= data_in;
            end else if (byte_port || !address[0]) begin
               if (transfer_size_code == bsz_pkg::SIZE_WORD) begin
                  rdata[bsz_pkg::BYTE_HI:8] <= data_in[bsz_pkg::BYTE_HI:8];
               end else begin
                  rdata[bsz_pkg::BYTE_LO:0] <= data_in[bsz_pkg::BYTE_HI:8];
               end
            end else begin
               if (transfer_size_code == bsz_pkg::SIZE_WORD) begin
                  rdata[bsz_pkg::BYTE_HI:8] <= data_in[bsz_pkg::BYTE_LO:0];
               end else begin
                  rdata[bsz_pkg::BYTE_LO:0] <= data_in[bsz_pkg::BYTE_LO:0];
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence split_seq;
      state == bsz_pkg::BSZ_NEXT ##1 state == bsz_pkg::BSZ_DRIVE;
   endsequence

   strobe_after_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && state == bsz_pkg::BSZ_DRIVE |=> address_strobe_n == 1'b0 || !clk_en)
      else $error("strobe not asserted after drive");
   no_three_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
      transfer_size_code != bsz_pkg::SIZE_THREE)
      else $error("three-byte size code issued");
   split_size_a: assert property (@(posedge clk) disable iff (!reset_n)
      split_seq |-> transfer_size_code == bsz_pkg::SIZE_BYTE && $past(address, 2) + 24'h000001 == address)
      else $error("second cycle not a byte at next address");
   byte_replicate_a: assert property (@(posedge clk) disable iff (!reset_n)
      data_oe && !data_strobe_n && transfer_size_code == bsz_pkg::SIZE_BYTE |-> data_out[15:8] == data_out[7:0])
      else $error("byte not replicated");
   hold_release_a: assert property (@(posedge clk) disable iff (!reset_n)
      state == bsz_pkg::BSZ_RELEASE && acked && clk_en |=> state == bsz_pkg::BSZ_RELEASE)
      else $error("left release with ack held");
   no_misalign_a: assert property (@(posedge clk) disable iff (!reset_n)
      state == bsz_pkg::BSZ_IDLE && clk_en && req_valid && !misalign_allowed && req_word && req_addr[0]
      |=> state == bsz_pkg::BSZ_IDLE && misalign_error)
      else $error("misaligned transfer started");
   hi_lane_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
      state == bsz_pkg::BSZ_WAIT && clk_en && acked && read_write && byte_port &&
      transfer_size_code == bsz_pkg::SIZE_BYTE |=> rdata[7:0] == $past(data_in[15:8]))
      else $error("byte port data not from upper lane");
   odd_lane_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
      state == bsz_pkg::BSZ_WAIT && clk_en && acked && read_write && !byte_port && address[0] &&
      transfer_size_code == bsz_pkg::SIZE_BYTE |=> rdata[7:0] == $past(data_in[7:0]))
      else $error("odd byte not from lower lane");
endmodule : bsz_core

// ===== verilog/bsz_pkg.sv
// Package of constants and types for the bus sizing block
// Assumes a single 25 MHz clock and an active-low asynchronous reset
package bsz_pkg;
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;
   localparam int ADDR_W = 24;
   localparam int FC_W = 3;
   localparam int DATA_W = 16;
   localparam int BYTE_HI = 15;
   localparam int BYTE_LO = 7;
   localparam int ACK_TIMEOUT_NS = 40000;
   localparam int CLK_NS = 40;
   localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_NS;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   typedef enum logic [2:0] {
      BSZ_IDLE,
      BSZ_DRIVE,
      BSZ_WAIT,
      BSZ_RELEASE,
      BSZ_NEXT
   } bsz_state_e;
endpackage : bsz_pkg

// ===== verilog/bsz_sync.sv
// Two-flop synchroniser for one active-low level
// Assumes the input may change at any time relative to clk
module bsz_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Level
   input wire logic async_n,
   output logic sync_n
);
   logic stage_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_n <= 1'b1;
         sync_n <= 1'b1;
      end else if (clk_en) begin
         stage_n <= async_n;
         sync_n <= stage_n;
      end
   end
endmodule : bsz_sync
